// *** ces_cpu_exception_sequencer.sv ***
/*
  exception entry sequencer: manual reset entry, address error detection,
  interrupt arbitration and the stack/vector sequence, with an axi4-lite
  register slave.
  assumes the cpu core supplies instruction boundaries and the return pc,
  and a memory port that answers each request with a one-cycle ack.
*/
`include "ces_params.svh"

// Behaviour
// - power-on pin high and manual pin low puts the cpu in manual reset
// - manual reset initialises cpu state only, peripheral registers kept
// - an open bus cycle completes before manual reset handling starts
// - manual pin release starts the same sequence as power-on reset
// - reset loads pc then sp from table, clears vector base, sets mask
// - vector fetch address is vector base plus four times vector number
// - instruction fetch from odd address raises address error
// - instruction fetch from peripheral space raises address error
// - single chip mode: any external space access raises address error
// - word data access at odd address raises address error
// - longword data access off four-byte boundary raises address error
// - peripheral space: longword to 8-bit region errors, others normal
// - address error handled after bus cycle and current instruction end
// - push status word then return pc of the following instruction
// - fetch address error vector and jump with no delay slot
// - eight irq pins, nmi, break, debug and peripheral sources accepted
// - each source owns a distinct vector number
// - levels 0 to 16, nmi fixed at 16 and always accepted
// - break controller and debug interface fixed at level 15
// - irq and peripheral levels programmable 0 to 15 only
// - highest pending priority wins arbitration
// - maskable interrupt accepted only when level exceeds mask field
// - push status word and pc, load level into mask, then vector
// - nmi writes fifteen into the mask field
module ces_cpu_exception_sequencer
  import ces_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter int NUM_PERIPH = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // axi4-lite write address and data
  input wire logic [31:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // axi4-lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [31:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // reset pins
  input wire logic I_POWER_ON_RESET_PIN_N,
  input wire logic I_MANUAL_RESET_PIN_N,
  // interrupt requests
  input wire logic I_NMI,
  input wire logic [NUM_IRQ-1:0] I_IRQ,
  input wire logic I_BREAK_CONTROLLER_REQ,
  input wire logic I_DEBUG_INTERFACE_REQUEST,
  input wire logic [NUM_PERIPH-1:0] I_PERIPH_REQ,
  // cpu core and bus monitor
  input wire logic I_BUS_BUSY,
  input wire logic I_INSN_DONE,
  input wire logic [31:0] I_NEXT_PC,
  input wire logic I_ACC_VALID,
  input wire logic I_ACC_FETCH,
  input wire logic [1:0] I_ACC_SIZE,
  input wire logic [31:0] I_ACC_ADDR,
  // stack and vector table memory port
  output logic O_MEM_REQ,
  output logic O_MEM_WE,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA,
  // cpu control
  output logic O_CPU_INIT,
  output logic O_PC_LOAD,
  output logic [31:0] O_PC,
  output logic [31:0] O_SP,
  output logic [3:0] O_MASK,
  output logic [7:0] O_VECTOR,
  output logic O_BUSY
);

  ces_st_t st_reg;
  ces_st_t st_next;
  logic [4:0] best_lvl;
  logic [7:0] best_vec;
  logic best_found;
  logic best_is_nmi;
  logic int_accept;
  logic acc_periph;
  logic acc_external;
  logic aerr_now;
  logic [3:0] cur_mask;
  logic [4:0] src_lvl;

  assign cur_mask = st_reg.sr[`CES_SR_MASK_MSB:`CES_SR_MASK_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // address error detection

  // space decode of the current access
  assign acc_periph = (I_ACC_ADDR[31:16] == `CES_PERIPH_TOP);
  assign acc_external = (I_ACC_ADDR[31:28] != `CES_INTERNAL_ROM_TOP) &&
                        (I_ACC_ADDR[31:24] != `CES_INTERNAL_RAM_TOP);

  // misaligned or illegal-space access
  always_comb begin
    aerr_now = 1'b0;
    if (I_ACC_VALID) begin
      if (I_ACC_FETCH) begin
        if (I_ACC_ADDR[0]) aerr_now = 1'b1;
        if (acc_periph) aerr_now = 1'b1;
      end else begin
        if ((I_ACC_SIZE == `CES_SIZE_WORD) && I_ACC_ADDR[0]) aerr_now = 1'b1;
        if ((I_ACC_SIZE == `CES_SIZE_LONG) && (I_ACC_ADDR[1:0] != 2'h0)) aerr_now = 1'b1;
        // 8-bit regions sit below the 16-bit ones in peripheral space
        if (acc_periph && (I_ACC_SIZE == `CES_SIZE_LONG) &&
            (I_ACC_ADDR[15:12] < `CES_PERIPH8_TOP)) aerr_now = 1'b1;
      end
      if (st_reg.single_chip && acc_external) aerr_now = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt arbitration

  // strict greater-than keeps the earlier source on a tie
  always_comb begin
    best_lvl = 5'h0;
    best_vec = 8'h0;
    best_found = 1'b0;
    best_is_nmi = 1'b0;
    src_lvl = 5'h0;
    if (st_reg.nmi_pend) begin
      best_lvl = `CES_LVL_NMI;
      best_vec = `CES_VEC_NMI;
      best_found = 1'b1;
      best_is_nmi = 1'b1;
    end
    if (I_BREAK_CONTROLLER_REQ && (!best_found || `CES_LVL_FIXED15 > best_lvl)) begin
      best_lvl = `CES_LVL_FIXED15;
      best_vec = `CES_VEC_BREAK;
      best_found = 1'b1;
    end
    if (I_DEBUG_INTERFACE_REQUEST && (!best_found || `CES_LVL_FIXED15 > best_lvl)) begin
      best_lvl = `CES_LVL_FIXED15;
      best_vec = `CES_VEC_DEBUG;
      best_found = 1'b1;
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      src_lvl = {1'b0, st_reg.prio_irq[4*i +: 4]};
      if (I_IRQ[i] && (!best_found || src_lvl > best_lvl)) begin
        best_lvl = src_lvl;
        best_vec = `CES_VEC_IRQ0 + 8'(i);
        best_found = 1'b1;
        best_is_nmi = 1'b0;
      end
    end
    for (int i = 0; i < NUM_PERIPH; i++) begin
      src_lvl = {1'b0, st_reg.prio_per[4*i +: 4]};
      if (I_PERIPH_REQ[i] && (!best_found || src_lvl > best_lvl)) begin
        best_lvl = src_lvl;
        best_vec = `CES_VEC_PERIPH0 + 8'(i);
        best_found = 1'b1;
        best_is_nmi = 1'b0;
      end
    end
  end

  // nmi always taken, others only above the mask
  assign int_accept = best_found && (best_is_nmi || (best_lvl > {1'b0, cur_mask}));

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    st_next = st_reg;
    st_next.pc_load = 1'b0;
    // nmi edge latch, set beats the acceptance clear
    st_next.nmi_prev = I_NMI;
    // address error latch, set beats clear
    if (aerr_now && !st_reg.aerr_pend) st_next.aerr_addr = I_ACC_ADDR;

    unique case (st_reg.state)
      S_IDLE: begin
        if (I_INSN_DONE && st_reg.aerr_pend) begin
          // error handled at instruction boundary
          st_next.aerr_pend = 1'b0;
          st_next.vec = `CES_VEC_CPU_AERR;
          st_next.new_mask = cur_mask;
          st_next.ret_pc = I_NEXT_PC;
          st_next.state = S_PUSH_SR;
        end else if (I_INSN_DONE && int_accept) begin
          st_next.vec = best_vec;
          st_next.new_mask = best_is_nmi ? `CES_MASK_ALL : best_lvl[3:0];
          if (best_is_nmi) st_next.nmi_pend = 1'b0;
          st_next.ret_pc = I_NEXT_PC;
          st_next.state = S_PUSH_SR;
        end
      end
      S_MR_WAIT: begin
        // manual reset never aborts an open bus cycle
        if (!I_BUS_BUSY) st_next.state = S_HOLD;
      end
      S_HOLD: begin
        // cpu state re-initialised, peripheral registers untouched
        st_next.aerr_pend = 1'b0;
        st_next.nmi_pend = 1'b0;
        if (I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N) begin
          st_next.state = S_RST_PC;
          st_next.mem_req = 1'b1;
          st_next.mem_we = 1'b0;
          st_next.mem_addr = {22'h0, `CES_VEC_RESET_PC, 2'h0};
        end
      end
      S_RST_PC: begin
        if (I_MEM_ACK) begin
          st_next.pc = I_MEM_RDATA;
          st_next.mem_addr = {22'h0, `CES_VEC_RESET_SP, 2'h0};
          st_next.state = S_RST_SP;
        end
      end
      S_RST_SP: begin
        if (I_MEM_ACK) begin
          st_next.sp = I_MEM_RDATA;
          st_next.vector_base = `CES_VBR_RESET;
          st_next.sr[`CES_SR_MASK_MSB:`CES_SR_MASK_LSB] = `CES_MASK_ALL;
          st_next.mem_req = 1'b0;
          st_next.pc_load = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      S_PUSH_SR: begin
        // first push: status word
        if (!st_reg.mem_req) begin
          st_next.mem_req = 1'b1;
          st_next.mem_we = 1'b1;
          st_next.mem_addr = st_reg.sp - 32'h4;
          st_next.mem_wdata = st_reg.sr;
          st_next.sp = st_reg.sp - 32'h4;
        end else if (I_MEM_ACK) begin
          st_next.mem_addr = st_reg.sp - 32'h4;
          st_next.mem_wdata = st_reg.ret_pc;
          st_next.sp = st_reg.sp - 32'h4;
          st_next.state = S_PUSH_PC;
        end
      end
      S_PUSH_PC: begin
        if (I_MEM_ACK) begin
          // mask updated before the handler is entered
          st_next.sr[`CES_SR_MASK_MSB:`CES_SR_MASK_LSB] = st_reg.new_mask;
          st_next.mem_we = 1'b0;
          st_next.mem_addr = st_reg.vector_base + {22'h0, st_reg.vec, 2'h0};
          st_next.state = S_FETCH_VEC;
        end
      end
      S_FETCH_VEC: begin
        if (I_MEM_ACK) begin
          st_next.pc = I_MEM_RDATA;
          st_next.mem_req = 1'b0;
          st_next.state = S_JUMP;
        end
      end
      S_JUMP: begin
        // direct jump, no delay slot
        st_next.pc_load = 1'b1;
        st_next.state = S_IDLE;
      end
      default: st_next.state = S_IDLE;
    endcase

    // latches whose set wins over the clear above
    if (aerr_now) st_next.aerr_pend = 1'b1;
    if (I_NMI && !st_reg.nmi_prev) st_next.nmi_pend = 1'b1;

    // power-on pin overrides everything; manual pin waits out an open bus cycle
    if (!I_POWER_ON_RESET_PIN_N) begin
      st_next.state = S_HOLD;
      st_next.mem_req = 1'b0;
    end else if (!I_MANUAL_RESET_PIN_N &&
                 (st_reg.state != S_HOLD) && (st_reg.state != S_MR_WAIT)) begin
      st_next.state = I_BUS_BUSY ? S_MR_WAIT : S_HOLD;
      st_next.mem_req = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    if (I_AWVALID && O_AWREADY) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      st_next.w_got = 1'b1;
      st_next.wdata = I_WDATA;
      st_next.wstrb = I_WSTRB;
    end
    // register write once both halves are held
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `CES_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (st_reg.wstrb[b]) begin
          unique case ({st_reg.awaddr[31:2], 2'h0})
            `CES_OFF_CTRL: if (b == 0) st_next.single_chip = st_reg.wdata[`CES_CTRL_SINGLE_CHIP];
            `CES_OFF_STATUS_WORD: st_next.sr[8*b +: 8] = st_reg.wdata[8*b +: 8];
            `CES_OFF_VECTOR_BASE: st_next.vector_base[8*b +: 8] = st_reg.wdata[8*b +: 8];
            `CES_OFF_PRIO_IRQ: st_next.prio_irq[8*b +: 8] = st_reg.wdata[8*b +: 8];
            `CES_OFF_PRIO_PERIPH: st_next.prio_per[8*b +: 8] = st_reg.wdata[8*b +: 8];
            default: ;
          endcase
        end
      end
      unique case ({st_reg.awaddr[31:2], 2'h0})
        `CES_OFF_CTRL, `CES_OFF_STATUS_WORD, `CES_OFF_VECTOR_BASE,
        `CES_OFF_STATE, `CES_OFF_PRIO_IRQ, `CES_OFF_PRIO_PERIPH, `CES_OFF_AERR_ADDR: ;
        default: st_next.bresp = `CES_RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && I_BREADY) st_next.bvalid = 1'b0;
    if (st_reg.rvalid && I_RREADY) st_next.rvalid = 1'b0;
    // read answer one cycle after the address is taken
    if (I_ARVALID && O_ARREADY) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `CES_RESP_OKAY;
      unique case ({I_ARADDR[31:2], 2'h0})
        `CES_OFF_CTRL: st_next.rdata = {31'h0, st_reg.single_chip};
        `CES_OFF_STATUS_WORD: st_next.rdata = st_reg.sr;
        `CES_OFF_VECTOR_BASE: st_next.rdata = st_reg.vector_base;
        `CES_OFF_STATE: st_next.rdata = {st_reg.vec, 13'h0, st_reg.aerr_pend, st_reg.nmi_pend, st_reg.state};
        `CES_OFF_PRIO_IRQ: st_next.rdata = st_reg.prio_irq;
        `CES_OFF_PRIO_PERIPH: st_next.rdata = st_reg.prio_per;
        `CES_OFF_AERR_ADDR: st_next.rdata = st_reg.aerr_addr;
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = `CES_RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st_reg <= '0;
      st_reg.state <= S_IDLE;
      st_reg.sr <= `CES_SR_RESET;
      st_reg.vector_base <= `CES_VBR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign O_AWREADY = !st_reg.aw_got && !st_reg.bvalid;
  assign O_WREADY = !st_reg.w_got && !st_reg.bvalid;
  assign O_BVALID = st_reg.bvalid;
  assign O_BRESP = st_reg.bresp;
  assign O_ARREADY = !st_reg.rvalid;
  assign O_RVALID = st_reg.rvalid;
  assign O_RDATA = st_reg.rdata;
  assign O_RRESP = st_reg.rresp;
  assign O_MEM_REQ = st_reg.mem_req;
  assign O_MEM_WE = st_reg.mem_we;
  assign O_MEM_ADDR = st_reg.mem_addr;
  assign O_MEM_WDATA = st_reg.mem_wdata;
  assign O_CPU_INIT = (st_reg.state == S_HOLD);
  assign O_PC_LOAD = st_reg.pc_load;
  assign O_PC = st_reg.pc;
  assign O_SP = st_reg.sp;
  assign O_MASK = cur_mask;
  assign O_VECTOR = st_reg.vec;
  assign O_BUSY = (st_reg.state != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_manual_reset_pin_n_enter: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_POWER_ON_RESET_PIN_N && !I_MANUAL_RESET_PIN_N && !I_BUS_BUSY && st_reg.state == S_IDLE
    |=> st_reg.state == S_HOLD && O_CPU_INIT)
    else $error("manual reset not entered");

  a_bus_not_aborted: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_POWER_ON_RESET_PIN_N && st_reg.state == S_MR_WAIT && I_BUS_BUSY
    |=> st_reg.state == S_MR_WAIT && !O_CPU_INIT)
    else $error("bus cycle aborted by manual reset");

  a_manual_reset_pin_n_release: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_HOLD && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N
    |=> st_reg.state == S_RST_PC && O_MEM_REQ && O_MEM_ADDR == 32'h0)
    else $error("reset sequence not started on release");

  a_reset_load: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_RST_SP && I_MEM_ACK && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N
    |=> O_PC_LOAD && st_reg.vector_base == 32'h0 && O_MASK == 4'hf && O_SP == $past(I_MEM_RDATA))
    else $error("reset sequence state wrong");

  a_vector_addr: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_FETCH_VEC |-> O_MEM_ADDR == st_reg.vector_base + {22'h0, st_reg.vec, 2'h0})
    else $error("vector address wrong");

  a_odd_fetch: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_ACC_VALID && I_ACC_FETCH && I_ACC_ADDR[0] |=> st_reg.aerr_pend)
    else $error("odd fetch not flagged");

  a_long_align: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_ACC_VALID && !I_ACC_FETCH && I_ACC_SIZE == 2'h2 && I_ACC_ADDR[1:0] != 2'h0 |=> st_reg.aerr_pend)
    else $error("misaligned longword not flagged");

  a_aerr_waits: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_IDLE && !I_INSN_DONE && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N
    |=> st_reg.state == S_IDLE)
    else $error("exception entered mid instruction");

  a_push_order: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_PUSH_SR && O_MEM_REQ && I_MEM_ACK && I_MANUAL_RESET_PIN_N && I_POWER_ON_RESET_PIN_N
    |-> O_MEM_WDATA == st_reg.sr ##1 O_MEM_WDATA == st_reg.ret_pc && O_MEM_ADDR == O_SP)
    else $error("stack push order wrong");

  a_mask_level: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_IDLE && I_INSN_DONE && !st_reg.aerr_pend && !st_reg.nmi_pend &&
    I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N
    |=> st_reg.state == S_IDLE || st_reg.new_mask > $past(O_MASK))
    else $error("interrupt taken at or below mask");

  a_nmi_mask: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st_reg.state == S_PUSH_PC && I_MEM_ACK && st_reg.vec == 8'h0b && I_MANUAL_RESET_PIN_N && I_POWER_ON_RESET_PIN_N
    |=> O_MASK == 4'hf)
    else $error("nmi mask not fifteen");

endmodule

// *** ces_cpu_exception_sequencer_test.sv ***
/*
  bench: register access, manual reset, access checks, interrupt entry.
  assumes ces_mem_model answers the sequencer's memory port.
*/
`include "ces_params.svh"
module ces_cpu_exception_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = `CES_RESP_OKAY;
  localparam logic [1:0] SE = `CES_RESP_SLVERR;
  logic I_CLK = '0, I_RESET = '1, I_AWVALID = '0, I_WVALID = '0, I_BREADY = '0, I_ARVALID = '0;
  logic I_RREADY = '0, I_POWER_ON_RESET_PIN_N = '1, I_MANUAL_RESET_PIN_N = '1, I_NMI = '0;
  logic I_BREAK_CONTROLLER_REQ = '0, I_DEBUG_INTERFACE_REQUEST = '0, I_BUS_BUSY = '0;
  logic I_INSN_DONE = '0, I_ACC_VALID = '0, I_ACC_FETCH = '0, I_MEM_ACK;
  logic [31:0] I_AWADDR = '0, I_WDATA = '0, I_ARADDR = '0, I_NEXT_PC = '0, I_ACC_ADDR = '0;
  logic [31:0] I_MEM_RDATA, O_RDATA, O_MEM_ADDR, O_MEM_WDATA, O_PC, O_SP, esp, esr, evbr;
  logic [7:0] I_IRQ = '0, I_PERIPH_REQ = '0, O_VECTOR;
  logic [3:0] I_WSTRB = 4'hf, O_MASK;
  logic [1:0] I_ACC_SIZE = '0, dly = '0, O_BRESP, O_RRESP;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_MEM_REQ, O_MEM_WE;
  logic O_CPU_INIT, O_PC_LOAD, O_BUSY;
  int miscompares = 0, checks = 0, cyc = 0;

  ces_cpu_exception_sequencer uut (.*);
  ces_mem_model far_mem (.i_clk(I_CLK), .i_req(O_MEM_REQ), .i_addr(O_MEM_ADDR), .i_delay(dly),
    .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));

  // 50 mhz clock
  initial forever #10 I_CLK = ~I_CLK;

  ////////////////////////////////////////////////////////////
  task automatic ck(input logic ok, input string m);
    checks++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    logic ra, rw;
    @(posedge I_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(negedge I_CLK);
      ra = O_AWREADY & I_AWVALID;
      rw = O_WREADY & I_WVALID;
      @(posedge I_CLK);
      if (ra) I_AWVALID <= 1'b0;
      if (rw) I_WVALID <= 1'b0;
    end while (I_AWVALID | I_WVALID);
    do @(negedge I_CLK); while (O_BVALID !== 1'b1);
    ck(O_BRESP === r, "write response");
    @(posedge I_CLK);
    I_BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge I_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do @(negedge I_CLK); while (O_ARREADY !== 1'b1);
    @(posedge I_CLK);
    I_ARVALID <= 1'b0;
    do @(negedge I_CLK); while (O_RVALID !== 1'b1);
    ck(O_RDATA === d && O_RRESP === r, "read data");
    @(posedge I_CLK);
    I_RREADY <= 1'b0;
  endtask

  // one memory access of the sequencer, judged while acked
  task automatic mem(input logic w, input logic [31:0] a, d);
    do @(negedge I_CLK); while (I_MEM_ACK !== 1'b1);
    ck(O_MEM_WE === w && O_MEM_ADDR === a && (!w || O_MEM_WDATA === d), "memory access");
  endtask

  // sources {per, dbg, brk, irq, nmi} and mask
  task automatic sm(input logic [3:0] m, input logic [18:0] s);
    @(posedge I_CLK);
    {I_PERIPH_REQ, I_DEBUG_INTERFACE_REQUEST, I_BREAK_CONTROLLER_REQ, I_IRQ, I_NMI} <= s;
    esr = {24'h0, m, 4'h0};
    wr(`CES_OFF_STATUS_WORD, esr, OK);
  endtask

  task automatic acc(input logic [35:0] t);
    @(posedge I_CLK);
    {I_ACC_FETCH, I_ACC_SIZE, I_ACC_ADDR} <= t[34:0];
    I_ACC_VALID <= 1'b1;
    @(posedge I_CLK);
    I_ACC_VALID <= 1'b0;
    repeat (3) @(negedge I_CLK);
    ck(O_BUSY === 1'b0, "entry before boundary");
  endtask

  // instruction boundary; e says whether an exception must be entered
  task automatic step(input logic e, input logic [7:0] v, input logic [3:0] m);
    logic [31:0] va;
    va = evbr + {22'h0, v, 2'h0};
    @(posedge I_CLK);
    I_INSN_DONE <= 1'b1;
    I_NEXT_PC <= {24'h00000c, v};
    @(posedge I_CLK);
    I_INSN_DONE <= 1'b0;
    if (!e) begin
      repeat (4) @(negedge I_CLK);
      ck(O_BUSY === 1'b0 && O_MEM_REQ === 1'b0, "unexpected entry");
      return;
    end
    mem(1'b1, esp - 32'h4, esr);
    mem(1'b1, esp - 32'h8, {24'h00000c, v});
    mem(1'b0, va, 32'h0);
    do @(negedge I_CLK); while (O_PC_LOAD !== 1'b1);
    ck(O_PC === va + 32'h1000 && O_MASK === m && O_VECTOR === v, "entry");
    esp = esp - 32'h8;
    esr[7:4] = m;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_manual;
    wr(`CES_OFF_VECTOR_BASE, 32'h300, OK);
    wr(`CES_OFF_PRIO_PERIPH, 32'h3, OK);
    wr(32'h40, 32'h1, SE);
    rd(32'h40, 32'h0, SE);
    @(posedge I_CLK);
    I_BUS_BUSY <= 1'b1;
    I_MANUAL_RESET_PIN_N <= 1'b0;
    repeat (24) @(posedge I_CLK);
    @(negedge I_CLK);
    ck(O_CPU_INIT === 1'b0, "bus cycle aborted");
    @(posedge I_CLK);
    I_BUS_BUSY <= 1'b0;
    repeat (2) @(negedge I_CLK);
    ck(O_CPU_INIT === 1'b1, "no manual reset");
    @(posedge I_CLK);
    I_MANUAL_RESET_PIN_N <= 1'b1;
    mem(1'b0, 32'h0, 32'h0);
    mem(1'b0, 32'h4, 32'h0);
    do @(negedge I_CLK); while (O_PC_LOAD !== 1'b1);
    ck(O_PC === 32'h1000 && O_SP === 32'h1004 && O_MASK === 4'hf, "reset load");
    // second manual reset with no bus cycle open
    @(posedge I_CLK);
    I_MANUAL_RESET_PIN_N <= 1'b0;
    repeat (26) @(posedge I_CLK);
    @(negedge I_CLK);
    ck(O_CPU_INIT === 1'b1, "no idle manual reset");
    @(posedge I_CLK);
    I_MANUAL_RESET_PIN_N <= 1'b1;
    mem(1'b0, 32'h0, 32'h0);
    mem(1'b0, 32'h4, 32'h0);
    do @(negedge I_CLK); while (O_PC_LOAD !== 1'b1);
    rd(`CES_OFF_VECTOR_BASE, 32'h0, OK);
    rd(`CES_OFF_PRIO_PERIPH, 32'h3, OK);
    esp = 32'h1004;
  endtask

  task automatic t_aerr;
    logic [35:0] tb [11] = '{36'hd_0000_0101, 36'h5_0000_0100,
      36'hd_ffff_9000, 36'h9_0000_0103, 36'ha_0000_0102,
      36'h2_0000_0104, 36'ha_ffff_1000, 36'h2_ffff_9000,
      36'h0_ffff_1003, 36'h8_2000_0000, 36'hd_2000_0000};
    wr(`CES_OFF_CTRL, 32'h1, OK);
    evbr = 32'h200;
    wr(`CES_OFF_VECTOR_BASE, evbr, OK);
    sm(4'hf, 19'h0);
    foreach (tb[i]) begin
      acc(tb[i]);
      step(tb[i][35], `CES_VEC_CPU_AERR, 4'hf);
    end
    rd(`CES_OFF_AERR_ADDR, 32'h2000_0000, OK);
  endtask

  task automatic t_irq;
    dly <= 2'h2;
    wr(`CES_OFF_PRIO_IRQ, 32'h0000_0955, OK);
    wr(`CES_OFF_PRIO_PERIPH, 32'h3, OK);
    sm(4'h9, 19'h0000e);
    step('0, '0, '0);
    sm(4'h8, 19'h0000e);
    step('1, `CES_VEC_IRQ0 + 8'h2, 4'h9);
    sm(4'h4, 19'h00006);
    step('1, `CES_VEC_IRQ0, 4'h5);
    sm(4'hf, 19'h00001);
    step('1, `CES_VEC_NMI, 4'hf);
    sm(4'he, 19'h00600);
    step('1, `CES_VEC_BREAK, 4'hf);
    sm(4'he, 19'h00400);
    step('1, `CES_VEC_DEBUG, 4'hf);
    sm(4'h3, 19'h00800);
    step('0, '0, '0);
    sm(4'h2, 19'h00800);
    step('1, `CES_VEC_PERIPH0, 4'h3);
    sm(4'h0, 19'h0);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge I_CLK);
    I_RESET <= 1'b0;
    rd(`CES_OFF_STATUS_WORD, `CES_SR_RESET, OK);
    t_manual;
    t_aerr;
    t_irq;
    report_and_stop;
  end

  // hang guard
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
endmodule

// *** ces_mem_model.sv ***
/*
  far-side memory for the sequencer's stack and vector table port.
  assumes one request at a time; i_delay sets how slowly it answers.
*/
module ces_mem_model (
  // request side
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_delay,
  // answer side
  output logic o_ack = 1'b0,
  output logic [31:0] o_rdata
);
  logic [1:0] cnt = 2'h0;

  // every table word holds its own address plus 1000h, garbage when idle
  assign o_rdata = o_ack ? i_addr + 32'h0000_1000 : ~i_addr;

  // one-cycle ack after i_delay wait cycles, then a gap
  always_ff @(posedge i_clk) begin
    if (o_ack || !i_req) begin
      o_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == i_delay) begin
      o_ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// *** ces_params.svh ***
/*
  constants of the exception sequencer: register offsets, field positions,
  reset values, vector numbers and address-space decode.
  assumes a 32-bit byte address space and aligned 32-bit register words.
*/
`ifndef CES_PARAMS_SVH
`define CES_PARAMS_SVH

// register byte offsets
`define CES_OFF_CTRL 32'h0000_0000
`define CES_OFF_STATUS_WORD 32'h0000_0004
`define CES_OFF_VECTOR_BASE 32'h0000_0008
`define CES_OFF_STATE 32'h0000_000c
`define CES_OFF_PRIO_IRQ 32'h0000_0010
`define CES_OFF_PRIO_PERIPH 32'h0000_0014
`define CES_OFF_AERR_ADDR 32'h0000_0018

// field positions
`define CES_CTRL_SINGLE_CHIP 0
`define CES_SR_MASK_LSB 4
`define CES_SR_MASK_MSB 7

// reset values
`define CES_SR_RESET 32'h0000_00f0
`define CES_VBR_RESET 32'h0000_0000
`define CES_MASK_ALL 4'hf

// vector numbers
`define CES_VEC_RESET_PC 8'h00
`define CES_VEC_RESET_SP 8'h01
`define CES_VEC_CPU_AERR 8'h09
`define CES_VEC_NMI 8'h0b
`define CES_VEC_BREAK 8'h0c
`define CES_VEC_DEBUG 8'h0e
`define CES_VEC_IRQ0 8'h40
`define CES_VEC_PERIPH0 8'h48

// fixed priority levels
`define CES_LVL_NMI 5'h10
`define CES_LVL_FIXED15 5'h0f

// address-space decode
`define CES_PERIPH_TOP 16'hffff
`define CES_PERIPH8_TOP 4'h8
`define CES_INTERNAL_ROM_TOP 4'h0
`define CES_INTERNAL_RAM_TOP 8'hff

// access sizes
`define CES_SIZE_BYTE 2'h0
`define CES_SIZE_WORD 2'h1
`define CES_SIZE_LONG 2'h2

// axi responses
`define CES_RESP_OKAY 2'h0
`define CES_RESP_SLVERR 2'h2

`endif

// *** ces_pkg.sv ***
/*
  types of the exception sequencer: sequencer states and the state record.
  assumes ces_params.svh is on the include path.
*/
package ces_pkg;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_MR_WAIT = 9'h002,
    S_HOLD = 9'h004,
    S_RST_PC = 9'h008,
    S_RST_SP = 9'h010,
    S_PUSH_SR = 9'h020,
    S_PUSH_PC = 9'h040,
    S_FETCH_VEC = 9'h080,
    S_JUMP = 9'h100
  } ces_state_t;

  // all state of the sequencer
  typedef struct packed {
    ces_state_t state;
    logic [31:0] sr;
    logic [31:0] vector_base;
    logic [31:0] sp;
    logic [31:0] ret_pc;
    logic [31:0] pc;
    logic pc_load;
    logic [7:0] vec;
    logic [3:0] new_mask;
    logic single_chip;
    logic [31:0] prio_irq;
    logic [31:0] prio_per;
    logic aerr_pend;
    logic [31:0] aerr_addr;
    logic nmi_pend;
    logic nmi_prev;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ces_st_t;

endpackage
